// *** verilog/hmp_pkg.sv ***
// Constants, register map and carrier types of the host mailbox port
package hmp_pkg;

    localparam int unsigned HMP_DW          = 8;
    localparam int unsigned HMP_AW          = 16;
    localparam int unsigned HMP_NCHAN       = 2;
    localparam int unsigned HMP_SYNC_STAGES = 3;

    // Slave CPU register addresses
    localparam logic [15:0] HMP_ADDR_SERIAL_TIMER_CONTROL = 16'hFFC3;
    localparam logic [15:0] HMP_ADDR_SYSTEM_CONTROL       = 16'hFFC4;
    localparam logic [15:0] HMP_ADDR_HOST_PORT_CONTROL    = 16'hFFF0;
    localparam logic [15:0] HMP_ADDR_CHAN1_INPUT_DATA     = 16'hFFF4;
    localparam logic [15:0] HMP_ADDR_CHAN1_OUTPUT_DATA    = 16'hFFF5;
    localparam logic [15:0] HMP_ADDR_CHAN1_STATUS         = 16'hFFF6;
    localparam logic [15:0] HMP_ADDR_CHAN2_INPUT_DATA     = 16'hFFFC;
    localparam logic [15:0] HMP_ADDR_CHAN2_OUTPUT_DATA    = 16'hFFFD;
    localparam logic [15:0] HMP_ADDR_CHAN2_STATUS         = 16'hFFFE;
    // Lowest address of the window gated by the enable bit
    localparam logic [15:0] HMP_ADDR_GATED_LO             = 16'hFFF0;

    localparam logic [1:0][15:0] HMP_ADDR_IDR =
        {HMP_ADDR_CHAN2_INPUT_DATA, HMP_ADDR_CHAN1_INPUT_DATA};
    localparam logic [1:0][15:0] HMP_ADDR_ODR =
        {HMP_ADDR_CHAN2_OUTPUT_DATA, HMP_ADDR_CHAN1_OUTPUT_DATA};
    localparam logic [1:0][15:0] HMP_ADDR_STR =
        {HMP_ADDR_CHAN2_STATUS, HMP_ADDR_CHAN1_STATUS};

    // Reset values
    localparam logic [7:0] HMP_RST_SERIAL_TIMER = 8'h00;
    localparam logic [7:0] HMP_RST_SYSTEM       = 8'h09;
    localparam logic [7:0] HMP_RST_PORT_CTRL    = 8'hF8;
    localparam logic [7:0] HMP_RST_STATUS       = 8'h00;
    localparam logic [7:0] HMP_RST_DATA         = 8'h00;

    // Field positions and masks
    localparam int unsigned HMP_SYS_ENABLE_BIT   = 1;
    localparam logic [7:0]  HMP_SYS_RO_MASK      = 8'h08;
    localparam int unsigned HMP_CTL_FAST_GATE    = 0;
    localparam logic [1:0][2:0] HMP_CTL_IRQ_BIT  = {3'h2, 3'h1};
    localparam logic [7:0]  HMP_CTL_FIXED_MASK   = 8'hF8;
    localparam int unsigned HMP_ST_CMD_BIT       = 3;
    localparam int unsigned HMP_ST_IBF_BIT       = 1;
    localparam int unsigned HMP_ST_OBF_BIT       = 0;
    localparam logic [7:0]  HMP_ST_SPARE_MASK    = 8'hF4;

    // Host pin group, all strobes active low
    typedef struct packed {
        logic       chan2_select_n;
        logic       chan1_select_n;
        logic       host_addr_line;
        logic       host_read_strobe_n;
        logic       host_write_strobe_n;
        logic [7:0] host_byte_bus;
    } hmp_pins_s;

    localparam int unsigned HMP_PINS_W = $bits(hmp_pins_s);
    localparam hmp_pins_s HMP_PINS_IDLE = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
                                            8'h00};

    // Slave CPU internal access, one-cycle strobes
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } hmp_cpu_req_s;

    typedef struct packed {
        logic [7:0] input_data;
        logic [7:0] output_data;
        logic [7:0] status;
    } hmp_chan_s;

endpackage

// *** verilog/hmp_pin_filter.sv ***
// Three-flop pin synchroniser with agreement filter, one lane per bit
module hmp_pin_filter
    import hmp_pkg::*;
#(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clk_sys,  // System clock
    input  wire logic         i_reset_n,  // Synchronous reset, low
    input  wire logic [W-1:0] i_async,    // Pins from the host
    output logic      [W-1:0] o_filt      // Filtered, clock aligned
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } filt_state_s;

    filt_state_s st_r;
    filt_state_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = i_async;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int b = 0; b < W; b++) begin
            // Only stages two and three decide; stage one feeds stage two
            if (st_r.s2[b] == st_r.s3[b]) begin
                st_nxt.filt[b] = st_r.s3[b];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            st_r <= '{RST, RST, RST, RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_filt = st_r.filt;

endmodule

// *** verilog/hmp_host_port.sv ***
// Dual channel host mailbox port: host pins, slave registers, flags
// How it works
// - Slave access to FFF0..FFFF only works while the port is enabled.
// - System control resets to 09; its bit 3 cannot be written.
// - Enable bit 0 shuts the host port off; 1 opens slave mode.
// - Host port control resets to F8.
// - Top five control bits ignore writes and read as ones.
// - Control bit 2 lets the channel 2 input-full interrupt through.
// - Control bit 1 lets the channel 1 input-full interrupt through.
// - Control bit 0 switches the fast gate function on.
// - Host write with select 1 low stores byte and address line.
// - Input data 1 is slave read-only, host write-only, resets to 00.
// - Output data 1 goes to host on read with address line low.
// - Status resets to 00; command, input and output flags read-only.
// - Status bits 7..4 and 2 are spare slave read-write storage.
// - Command flag copies the address line on each host write.
// - Input-full sets on host write, clears on slave read.
// - Output-full sets on slave write, clears on host read of output data.
// - Input-full, masked by its enable, interrupts the slave CPU.
// - Address line marks command or data, or picks status or data.
// - Channel 2 sits at FFFC..FFFE, picked by select 2 alone.
// - Host write with select 2 low stores byte into channel 2.
// - Output data 2 goes to host on read with address line low.
// - Channel 2 input-full sets on host write, clears on slave read.
module hmp_host_port
    import hmp_pkg::*;
(
    input  wire logic         i_clk_sys,           // 250 MHz clock
    input  wire logic         i_reset_n,           // Sync reset, low
    // Slave CPU internal access
    input  wire hmp_cpu_req_s i_cpu_req,           // Address, strobes
    output logic [7:0]        o_cpu_rdata,         // Read data
    // Host pins
    input  wire logic         i_chan1_select_n,    // Channel 1 select
    input  wire logic         i_chan2_select_n,    // Channel 2 select
    input  wire logic         i_host_addr_line,    // Command/status pick
    input  wire logic         i_host_read_strobe_n,  // Host read, low
    input  wire logic         i_host_write_strobe_n, // Host write, low
    input  wire logic [7:0]   i_host_byte_bus,     // Bus level in
    output logic      [7:0]   o_host_byte_bus,     // Bus drive value
    output logic              o_host_byte_bus_oe,  // High while driving
    // Slave side outputs
    output logic              o_chan1_full_irq,    // Channel 1 interrupt
    output logic              o_chan2_full_irq,    // Channel 2 interrupt
    output logic              o_port_enable_bit,   // Slave mode active
    output logic              o_fast_gate_enable,  // Fast gate on
    output logic [7:0]        o_system_control,    // Whole register
    output logic [7:0]        o_serial_timer_control // Whole register
);

    typedef struct packed {
        logic [7:0]                 serial_timer_control;
        logic [7:0]                 system_control;
        logic [7:0]                 host_port_control;
        hmp_chan_s [HMP_NCHAN-1:0]  chan;
        hmp_pins_s                  prev;
        logic [7:0]                 rdata;
        logic [7:0]                 host_out;
        logic                       host_oe;
        logic [HMP_NCHAN-1:0]       irq;
    } hmp_state_s;

    localparam hmp_chan_s HMP_CHAN_RST =
        '{HMP_RST_DATA, HMP_RST_DATA, HMP_RST_STATUS};

    localparam hmp_state_s HMP_STATE_RST = '{
        serial_timer_control: HMP_RST_SERIAL_TIMER,
        system_control:       HMP_RST_SYSTEM,
        host_port_control:    HMP_RST_PORT_CTRL,
        chan:                 {HMP_CHAN_RST, HMP_CHAN_RST},
        prev:                 HMP_PINS_IDLE,
        rdata:                HMP_RST_DATA,
        host_out:             HMP_RST_DATA,
        host_oe:              1'b0,
        irq:                  '0
    };

    hmp_state_s st_r;
    hmp_state_s st_nxt;
    hmp_pins_s  pins_raw;
    hmp_pins_s  pins;
    logic [HMP_PINS_W-1:0] pins_filt;

    assign pins_raw = '{i_chan2_select_n, i_chan1_select_n,
                        i_host_addr_line, i_host_read_strobe_n,
                        i_host_write_strobe_n, i_host_byte_bus};

    // Strobes, selects and data all share the same latency
    hmp_pin_filter #(
        .W   (HMP_PINS_W),
        .RST (HMP_PINS_IDLE)
    ) u_pin_filter (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   (pins_raw),
        .o_filt    (pins_filt)
    );

    assign pins = hmp_pins_s'(pins_filt);

    // Channel picked by exactly one select; both low is prohibited
    function automatic logic one_select(input hmp_pins_s p);
        return p.chan1_select_n != p.chan2_select_n;
    endfunction

    function automatic int unsigned sel_chan(input hmp_pins_s p);
        return p.chan1_select_n ? 1 : 0;
    endfunction

    logic       enabled;
    logic       wr_rise;
    logic       rd_rise;
    logic       prev_ok;
    logic       cur_read;
    logic       gated;
    logic [7:0] ctl;

    always_comb begin
        st_nxt   = st_r;
        enabled  = st_r.system_control[HMP_SYS_ENABLE_BIT];
        ctl      = st_r.host_port_control;
        gated    = i_cpu_req.addr >= HMP_ADDR_GATED_LO;

        // Host edges judged on the cycle the filtered strobe returns high
        prev_ok  = enabled && one_select(st_r.prev);
        wr_rise  = !st_r.prev.host_write_strobe_n &&
                   pins.host_write_strobe_n;
        rd_rise  = !st_r.prev.host_read_strobe_n &&
                   pins.host_read_strobe_n;
        st_nxt.prev = pins;

        // Slave CPU read path
        st_nxt.rdata = HMP_RST_DATA;
        if (i_cpu_req.rd) begin
            if (i_cpu_req.addr == HMP_ADDR_SERIAL_TIMER_CONTROL) begin
                st_nxt.rdata = st_r.serial_timer_control;
            end else if (i_cpu_req.addr == HMP_ADDR_SYSTEM_CONTROL) begin
                st_nxt.rdata = st_r.system_control;
            end else if (gated && !enabled) begin
                st_nxt.rdata = HMP_RST_DATA;
            end else if (i_cpu_req.addr == HMP_ADDR_HOST_PORT_CONTROL) begin
                st_nxt.rdata = ctl | HMP_CTL_FIXED_MASK;
            end else begin
                for (int c = 0; c < HMP_NCHAN; c++) begin
                    if (i_cpu_req.addr == HMP_ADDR_IDR[c]) begin
                        st_nxt.rdata = st_r.chan[c].input_data;
                        // Slave read empties the buffer
                        st_nxt.chan[c].status[HMP_ST_IBF_BIT] = 1'b0;
                    end else if (i_cpu_req.addr == HMP_ADDR_ODR[c]) begin
                        st_nxt.rdata = st_r.chan[c].output_data;
                    end else if (i_cpu_req.addr == HMP_ADDR_STR[c]) begin
                        st_nxt.rdata = st_r.chan[c].status;
                    end
                end
            end
        end

        // Host read of output data frees it
        if (rd_rise && prev_ok && st_r.prev.host_write_strobe_n &&
            !st_r.prev.host_addr_line) begin
            st_nxt.chan[sel_chan(st_r.prev)].status[HMP_ST_OBF_BIT] =
                1'b0;
        end

        // Host write: byte, command flag, input-full; set beats clear
        if (wr_rise && prev_ok && st_r.prev.host_read_strobe_n) begin
            st_nxt.chan[sel_chan(st_r.prev)].input_data =
                st_r.prev.host_byte_bus;
            st_nxt.chan[sel_chan(st_r.prev)].status[HMP_ST_CMD_BIT] =
                st_r.prev.host_addr_line;
            st_nxt.chan[sel_chan(st_r.prev)].status[HMP_ST_IBF_BIT] =
                1'b1;
        end

        // Slave CPU write path
        if (i_cpu_req.wr) begin
            if (i_cpu_req.addr == HMP_ADDR_SERIAL_TIMER_CONTROL) begin
                st_nxt.serial_timer_control = i_cpu_req.wdata;
            end else if (i_cpu_req.addr == HMP_ADDR_SYSTEM_CONTROL) begin
                st_nxt.system_control =
                    (i_cpu_req.wdata & ~HMP_SYS_RO_MASK) |
                    (st_r.system_control & HMP_SYS_RO_MASK);
            end else if (gated && !enabled) begin
                st_nxt.serial_timer_control = st_r.serial_timer_control;
                // Whole window dead while disabled
            end else if (i_cpu_req.addr == HMP_ADDR_HOST_PORT_CONTROL) begin
                st_nxt.host_port_control =
                    i_cpu_req.wdata | HMP_CTL_FIXED_MASK;
            end else begin
                for (int c = 0; c < HMP_NCHAN; c++) begin
                    if (i_cpu_req.addr == HMP_ADDR_ODR[c]) begin
                        st_nxt.chan[c].output_data = i_cpu_req.wdata;
                        // Slave write wins over a same-cycle host read
                        st_nxt.chan[c].status[HMP_ST_OBF_BIT] =
                            1'b1;
                    end else if (i_cpu_req.addr == HMP_ADDR_STR[c]) begin
                        st_nxt.chan[c].status =
                            (i_cpu_req.wdata & HMP_ST_SPARE_MASK) |
                            (st_nxt.chan[c].status &
                             ~HMP_ST_SPARE_MASK);
                    end
                end
            end
        end

        // Drive the host bus only for a clean read of one channel
        cur_read = enabled && one_select(pins) &&
                   !pins.host_read_strobe_n &&
                   pins.host_write_strobe_n;
        st_nxt.host_oe  = cur_read;
        st_nxt.host_out = HMP_RST_DATA;
        if (cur_read) begin
            if (pins.host_addr_line) begin
                st_nxt.host_out = st_r.chan[sel_chan(pins)].status;
            end else begin
                st_nxt.host_out =
                    st_r.chan[sel_chan(pins)].output_data;
            end
        end

        // Interrupt requests to the slave CPU
        for (int c = 0; c < HMP_NCHAN; c++) begin
            st_nxt.irq[c] = st_nxt.chan[c].status[HMP_ST_IBF_BIT] &&
                            st_nxt.host_port_control[HMP_CTL_IRQ_BIT[c]];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            st_r <= HMP_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_cpu_rdata            = st_r.rdata;
    assign o_host_byte_bus        = st_r.host_out;
    assign o_host_byte_bus_oe     = st_r.host_oe;
    assign o_chan1_full_irq       = st_r.irq[0];
    assign o_chan2_full_irq       = st_r.irq[1];
    assign o_port_enable_bit      = st_r.system_control[HMP_SYS_ENABLE_BIT];
    assign o_fast_gate_enable     =
        st_r.host_port_control[HMP_CTL_FAST_GATE];
    assign o_system_control       = st_r.system_control;
    assign o_serial_timer_control = st_r.serial_timer_control;

endmodule

// *** verification/hmp_host_port_sva.sv ***
// Assertions on the host mailbox port pins and slave bus
module hmp_host_port_sva
    import hmp_pkg::*;
(
    input wire logic         i_clk_sys,              // Clock
    input wire logic         i_reset_n,              // Sync reset, low
    input wire hmp_cpu_req_s i_cpu_req,              // Slave access
    input wire logic [7:0]   o_cpu_rdata,            // Slave read data
    input wire logic         i_chan1_select_n,       // Channel 1 select
    input wire logic         i_chan2_select_n,       // Channel 2 select
    input wire logic         i_host_addr_line,       // Address line
    input wire logic         i_host_read_strobe_n,   // Host read
    input wire logic         i_host_write_strobe_n,  // Host write
    input wire logic [7:0]   i_host_byte_bus,        // Bus level
    input wire logic [7:0]   o_host_byte_bus,        // Bus drive value
    input wire logic         o_host_byte_bus_oe,     // Bus drive enable
    input wire logic         o_chan1_full_irq,       // Channel 1 irq
    input wire logic         o_chan2_full_irq,       // Channel 2 irq
    input wire logic         o_port_enable_bit,      // Port enabled
    input wire logic         o_fast_gate_enable,     // Fast gate on
    input wire logic [7:0]   o_system_control,       // System control
    input wire logic [7:0]   o_serial_timer_control  // Serial control
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    logic rd_ctl;
    assign rd_ctl = i_cpu_req.rd && o_port_enable_bit;

    a_sysctl_fixed: assert property (
        o_system_control[3])
        else $error("system control bit 3 not set");
    a_enable_mirror: assert property (
        !o_port_enable_bit |=> !o_host_byte_bus_oe)
        else $error("bus driven while port disabled");
    a_gated_read: assert property (
        i_cpu_req.rd && !o_port_enable_bit
        && i_cpu_req.addr >= HMP_ADDR_GATED_LO |=> o_cpu_rdata == 8'h00)
        else $error("gated register read returned data");
    a_ctl_fixed: assert property (
        rd_ctl && i_cpu_req.addr == HMP_ADDR_HOST_PORT_CONTROL
        |=> o_cpu_rdata[7:3] == 5'h1F)
        else $error("control upper bits not all ones");
    a_irq_clear: assert property (
        rd_ctl && i_cpu_req.addr == HMP_ADDR_CHAN1_INPUT_DATA
        |=> !o_chan1_full_irq)
        else $error("input-full interrupt stayed after read");
    a_oe_rise: assert property (
        $rose(o_host_byte_bus_oe)
        |-> o_port_enable_bit && !i_host_read_strobe_n)
        else $error("bus driven without a host read");
    a_oe_drop: assert property (
        i_host_read_strobe_n [*8] |-> !o_host_byte_bus_oe)
        else $error("bus still driven after read ended");
    a_bus_idle: assert property (
        !o_host_byte_bus_oe |-> o_host_byte_bus == 8'h00)
        else $error("bus value nonzero while not driving");
    a_gate_by_write: assert property (
        $changed(o_fast_gate_enable) |-> $past(i_cpu_req.wr)
        && $past(i_cpu_req.addr) == HMP_ADDR_HOST_PORT_CONTROL)
        else $error("fast gate changed without control write");
endmodule

bind hmp_host_port hmp_host_port_sva u_sva (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cpu_req(i_cpu_req),
    .o_cpu_rdata(o_cpu_rdata), .i_chan1_select_n(i_chan1_select_n),
    .i_chan2_select_n(i_chan2_select_n),
    .i_host_addr_line(i_host_addr_line),
    .i_host_read_strobe_n(i_host_read_strobe_n),
    .i_host_write_strobe_n(i_host_write_strobe_n),
    .i_host_byte_bus(i_host_byte_bus), .o_host_byte_bus(o_host_byte_bus),
    .o_host_byte_bus_oe(o_host_byte_bus_oe),
    .o_chan1_full_irq(o_chan1_full_irq),
    .o_chan2_full_irq(o_chan2_full_irq),
    .o_port_enable_bit(o_port_enable_bit),
    .o_fast_gate_enable(o_fast_gate_enable),
    .o_system_control(o_system_control),
    .o_serial_timer_control(o_serial_timer_control)
);

// *** verification/hmp_host_model.sv ***
// Behavioural host processor driving the mailbox port pins
module hmp_host_model
    import hmp_pkg::*;
(
    input  wire logic       i_clk_sys,  // Clock
    input  wire logic [7:0] i_dev_bus,  // Device drive value
    input  wire logic       i_dev_oe,   // Device drives bus
    output hmp_pins_s       o_pins      // Pins with resolved bus
);
    timeunit 1ns;
    timeprecision 1ps;

    hmp_pins_s  pins_r = HMP_PINS_IDLE;
    logic       host_oe = 1'b0;
    logic [7:0] host_dat = 8'h00;
    logic [7:0] float_r = 8'h00;
    logic [7:0] level;

    // Floating bus toggles so a stale value never passes for data
    assign level = (i_dev_oe === 1'b1) ? i_dev_bus :
                   (host_oe ? host_dat : float_r);
    always_ff @(posedge i_clk_sys) float_r <= ~level;
    always_comb begin
        o_pins = pins_r;
        o_pins.host_byte_bus = level;
    end

    // Never both strobes low; select and address held around the strobe
    task automatic xfer(input int ch, input logic a0, input logic wr,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge i_clk_sys);
        pins_r.chan1_select_n = (ch != 1);
        pins_r.chan2_select_n = (ch != 2);
        pins_r.host_addr_line = a0;
        host_dat = d;
        host_oe = wr;
        repeat (8) @(negedge i_clk_sys);
        pins_r.host_write_strobe_n = !wr;
        pins_r.host_read_strobe_n = wr;
        repeat (10) @(negedge i_clk_sys);
        q = level;
        pins_r.host_write_strobe_n = 1'b1;
        pins_r.host_read_strobe_n = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        pins_r = HMP_PINS_IDLE;
        host_oe = 1'b0;
        repeat (8) @(negedge i_clk_sys);
    endtask
endmodule

// *** verification/tb_hmp_host_port.sv ***
// Self-checking bench for the dual channel host mailbox port
module tb_hmp_host_port
    import hmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         i_clk_sys;
    logic         i_reset_n = 1'b0;
    hmp_cpu_req_s req = '0;
    hmp_pins_s    pins;
    logic [7:0]   rdata, dev_bus, sysc, stc;
    logic         dev_oe, irq1, irq2, en, fg;
    int           fails = 0;
    int           check_count = 0;

    hmp_host_port u_hmp_host_port (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cpu_req(req),
        .o_cpu_rdata(rdata), .i_chan1_select_n(pins.chan1_select_n),
        .i_chan2_select_n(pins.chan2_select_n),
        .i_host_addr_line(pins.host_addr_line),
        .i_host_read_strobe_n(pins.host_read_strobe_n),
        .i_host_write_strobe_n(pins.host_write_strobe_n),
        .i_host_byte_bus(pins.host_byte_bus), .o_host_byte_bus(dev_bus),
        .o_host_byte_bus_oe(dev_oe), .o_chan1_full_irq(irq1),
        .o_chan2_full_irq(irq2), .o_port_enable_bit(en),
        .o_fast_gate_enable(fg), .o_system_control(sysc),
        .o_serial_timer_control(stc));
    hmp_host_model u_host (.i_clk_sys(i_clk_sys), .i_dev_bus(dev_bus),
        .i_dev_oe(dev_oe), .o_pins(pins));

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, msg, seen, exp);
        end
    endtask

    task automatic cpu(input logic wr, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge i_clk_sys);
        req = '{a, !wr, wr, d};
        @(negedge i_clk_sys);
        req.rd = 1'b0;
        req.wr = 1'b0;
        q = rdata;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
                          input string msg);
        logic [7:0] q;
        cpu(1'b0, a, 8'h00, q);
        check(q, e, msg);
    endtask

    task automatic t_reset_gate();
        logic [7:0] q;
        check(sysc, HMP_RST_SYSTEM, "sysctl port");
        check(stc, HMP_RST_SERIAL_TIMER, "serial_timer_control port");
        rd_chk(HMP_ADDR_SYSTEM_CONTROL, 8'h09, "sysctl");
        cpu(1'b1, HMP_ADDR_CHAN1_OUTPUT_DATA, 8'h55, q);
        rd_chk(HMP_ADDR_HOST_PORT_CONTROL, 8'h00, "gated read");
        cpu(1'b1, HMP_ADDR_SYSTEM_CONTROL, 8'h02, q);
        check(en, 8'h01, "enable");
        rd_chk(HMP_ADDR_SYSTEM_CONTROL, 8'h0A, "bit3 ro");
        rd_chk(HMP_ADDR_CHAN1_STATUS, 8'h00, "gated write");
    endtask

    task automatic t_ctl_status();
        logic [7:0] q;
        rd_chk(HMP_ADDR_HOST_PORT_CONTROL, 8'hF8, "ctl reset");
        cpu(1'b1, HMP_ADDR_HOST_PORT_CONTROL, 8'h00, q);
        rd_chk(HMP_ADDR_HOST_PORT_CONTROL, 8'hF8, "ctl fixed");
        cpu(1'b1, HMP_ADDR_HOST_PORT_CONTROL, 8'h01, q);
        check(fg, 8'h01, "fast gate");
        rd_chk(HMP_ADDR_HOST_PORT_CONTROL, 8'hF9, "ctl rw");
        for (int c = 0; c < 2; c++) begin
            cpu(1'b1, HMP_ADDR_STR[c], 8'hFF, q);
            rd_chk(HMP_ADDR_STR[c], HMP_ST_SPARE_MASK, "spare");
            cpu(1'b1, HMP_ADDR_STR[c], 8'h00, q);
            rd_chk(HMP_ADDR_STR[c], 8'h00, "flags ro");
        end
    endtask

    task automatic t_host_write();
        logic [7:0] q, d;
        logic       a, c;
        for (int i = 0; i < 4; i++) begin
            c = i[1];
            a = i[0];
            d = 8'hA0 | 8'(i);
            // Command writes enable own channel, data writes only the other
            cpu(1'b1, HMP_ADDR_HOST_PORT_CONTROL, (a ^ c) ? 8'h02 : 8'h04, q);
            u_host.xfer(c ? 2 : 1, a, 1'b1, d, q);
            check(c ? irq2 : irq1, {7'h0, a}, "irq");
            rd_chk(HMP_ADDR_STR[c], {4'h0, a, 3'b010}, "set");
            rd_chk(HMP_ADDR_IDR[c], d, "data");
            check(c ? irq2 : irq1, 8'h00, "irq clr");
            rd_chk(HMP_ADDR_STR[c], {4'h0, a, 3'b000}, "clr");
        end
    endtask

    task automatic t_host_read();
        logic [7:0] q, d;
        for (int c = 0; c < 2; c++) begin
            d = 8'h3C + 8'(c);
            cpu(1'b1, HMP_ADDR_ODR[c], d, q);
            rd_chk(HMP_ADDR_STR[c], 8'h09, "obf set");
            u_host.xfer(c + 1, 1'b1, 1'b0, 8'h00, q);
            check(q, 8'h09, "host status");
            u_host.xfer(c + 1, 1'b0, 1'b0, 8'h00, q);
            check(q, d, "host data");
            rd_chk(HMP_ADDR_STR[c], 8'h08, "obf clr");
        end
    endtask

    task automatic t_disable();
        logic [7:0] q;
        cpu(1'b1, HMP_ADDR_SYSTEM_CONTROL, 8'h00, q);
        check(en, 8'h00, "disabled");
        u_host.xfer(1, 1'b0, 1'b1, 8'h77, q);
        cpu(1'b1, HMP_ADDR_SYSTEM_CONTROL, 8'h02, q);
        rd_chk(HMP_ADDR_CHAN1_STATUS, 8'h08, "write ignored");
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this bound is generous
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        end_sim();
    end

    initial begin
        repeat (4) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        t_reset_gate();
        t_ctl_status();
        t_host_write();
        t_host_read();
        t_disable();
        end_sim();
    end
endmodule
